// file: dv/tlic_core_model.sv
`timescale 1ns/100ps
module tlic_core_model (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Controller outputs
  input  wire tlic_pkg::tlic_core_t core_out,
  // Bench control
  input  wire logic                 ack_en,
  input  wire logic [3:0]           ack_dly,
  // Core sequencer pulses
  output logic                      irq_ack,
  output logic                      return_from_irq_instr,
  // Observation
  output logic [20:0]               vec_q,
  output logic [7:0]                n_load
);
  logic [3:0] wait_q;

  initial return_from_irq_instr = 1'b0;

  // Accept after ack_dly cycles; the guard stops a second ack on the stale req
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      wait_q  <= 4'h0;
      vec_q   <= 21'h000000;
      n_load  <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      if (core_out.pc_load && core_out.stack_push) n_load <= n_load + 8'h01;
      if (ack_en && core_out.req && !irq_ack) begin
        if (wait_q == ack_dly) begin
          irq_ack <= 1'b1;
          vec_q   <= core_out.vector;
          wait_q  <= 4'h0;
        end else wait_q <= wait_q + 4'h1;
      end else wait_q <= 4'h0;
    end
  end

  // One-cycle return pulse, launched just after an edge
  task ret_pulse();
    @(posedge pclk) return_from_irq_instr <= 1'b1;
    @(posedge pclk) return_from_irq_instr <= 1'b0;
  endtask : ret_pulse
endmodule : tlic_core_model

// file: dv/two_level_interrupt_controller_tb.sv
`timescale 1ns/100ps
module two_level_interrupt_controller_tb;
  logic                      pclk;
  logic                      presetn;
  tlic_pkg::tlic_apb_req_t   apb_req;
  tlic_pkg::tlic_apb_rsp_t   apb_rsp;
  logic                      timer0_overflow;
  logic                      ext_irq_pin_zero;
  logic [3:0]                upper_port_b_pins;
  logic                      port_b_read;
  logic [tlic_pkg::NPER-1:0] periph_irq_flag;
  logic                      irq_ack;
  logic                      return_from_irq_instr;
  tlic_pkg::tlic_core_t      core_out;
  logic                      ack_en;
  logic [3:0]                ack_dly;
  logic [20:0]               vec_q;
  logic [7:0]                n_load;
  logic [31:0]               rdata;
  logic                      err;
  int                        n_mismatch;
  int                        cmp_count;
  int                        cycles;
  int                        n;

  tlic_top dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .timer0_overflow(timer0_overflow), .ext_irq_pin_zero(ext_irq_pin_zero),
    .upper_port_b_pins(upper_port_b_pins), .port_b_read(port_b_read),
    .periph_irq_flag(periph_irq_flag), .irq_ack(irq_ack),
    .return_from_irq_instr(return_from_irq_instr), .core_out(core_out));

  tlic_core_model core (.pclk(pclk), .presetn(presetn), .core_out(core_out), .ack_en(ack_en),
    .ack_dly(ack_dly), .irq_ack(irq_ack), .return_from_irq_instr(return_from_irq_instr),
    .vec_q(vec_q), .n_load(n_load));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Hang guard: the tests need well under this many cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  // APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= w;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge pclk) apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rdata = apb_rsp.prdata;
    err   = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    apb(1'b0, a, 32'h00000000);
    chk(rdata, {24'h000000, exp}, what);
  endtask : rdchk

  task pulse_tmr();
    @(posedge pclk) timer0_overflow <= 1'b1;
    @(posedge pclk) timer0_overflow <= 1'b0;
  endtask : pulse_tmr

  // Count settled cycles until a request shows, bounded
  task wait_req();
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (core_out.req !== 1'b1 && n < 20);
  endtask : wait_req

  task t_reset();
    rdchk(tlic_pkg::OFF_MAIN, tlic_pkg::RST_MAIN, "main reset");
    rdchk(tlic_pkg::OFF_CTRL, tlic_pkg::RST_CTRL, "ctrl reset");
    rdchk(tlic_pkg::OFF_PERIPH, tlic_pkg::RST_PERIPH, "periph reset");
    rdchk(8'h10, 8'h00, "unmapped data");
    chk(32'(err), 32'h1, "unmapped error");
    wr(tlic_pkg::OFF_STATUS, 8'hff);
    chk(32'(err), 32'h1, "status write error");
    $display("test reset done");
  endtask : t_reset

  task t_compat_timer();
    wr(tlic_pkg::OFF_CTRL, 8'h41);
    pulse_tmr();
    rdchk(tlic_pkg::OFF_MAIN, 8'h04, "flag without enables");
    chk(32'(core_out.req), 32'h0, "no req while disabled");
    ack_dly <= 4'h3;
    ack_en  <= 1'b1;
    wr(tlic_pkg::OFF_MAIN, 8'ha4);
    wait_req();
    chk(32'(core_out.vector), 32'(tlic_pkg::VEC_HIGH), "compat vector");
    repeat (8) @(posedge pclk);
    chk(32'(vec_q), 32'(tlic_pkg::VEC_HIGH), "accepted vector");
    chk(32'(n_load), 32'h1, "push and load once");
    rdchk(tlic_pkg::OFF_MAIN, 8'h24, "gie cleared");
    wr(tlic_pkg::OFF_MAIN, 8'h20);
    core.ret_pulse();
    rdchk(tlic_pkg::OFF_MAIN, 8'ha0, "gie restored");
    wr(tlic_pkg::OFF_MAIN, 8'h00);
    $display("test compat timer done");
  endtask : t_compat_timer

  task t_pin();
    ack_en  <= 1'b0;
    ack_dly <= 4'h0;
    wr(tlic_pkg::OFF_MAIN, 8'h90);
    @(posedge pclk) ext_irq_pin_zero <= 1'b1;
    wait_req();
    chk(32'(n >= 3 && n <= 4), 32'h1, "pin latency");
    rdchk(tlic_pkg::OFF_MAIN, 8'h92, "pin flag");
    ext_irq_pin_zero <= 1'b0;
    ack_en <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(tlic_pkg::OFF_MAIN, 8'h00);
    core.ret_pulse();
    rdchk(tlic_pkg::OFF_MAIN, 8'h80, "return sets gie");
    wr(tlic_pkg::OFF_MAIN, 8'h00);
    $display("test pin done");
  endtask : t_pin

  task t_prio();
    wr(tlic_pkg::OFF_CTRL, 8'hc1);
    wr(tlic_pkg::OFF_MAIN, 8'h60);
    pulse_tmr();
    repeat (4) @(posedge pclk);
    chk(32'(core_out.req), 32'h0, "bit7 clear blocks all");
    wr(tlic_pkg::OFF_MAIN, 8'he4);
    wait_req();
    chk(32'(core_out.vector), 32'(tlic_pkg::VEC_LOW), "low vector");
    repeat (4) @(posedge pclk);
    rdchk(tlic_pkg::OFF_MAIN, 8'ha4, "low enable cleared");
    ack_en <= 1'b0;
    wr(tlic_pkg::OFF_MAIN, 8'hb0);
    @(posedge pclk) ext_irq_pin_zero <= 1'b1;
    wait_req();
    chk(32'(core_out.vector), 32'(tlic_pkg::VEC_HIGH), "high preempts low");
    ack_en <= 1'b1;
    repeat (4) @(posedge pclk);
    rdchk(tlic_pkg::OFF_MAIN, 8'h32, "high enable cleared");
    wr(tlic_pkg::OFF_MAIN, 8'h30);
    core.ret_pulse();
    rdchk(tlic_pkg::OFF_MAIN, 8'hb0, "leave high first");
    core.ret_pulse();
    rdchk(tlic_pkg::OFF_MAIN, 8'hf0, "then leave low");
    ext_irq_pin_zero <= 1'b0;
    wr(tlic_pkg::OFF_MAIN, 8'h00);
    wr(tlic_pkg::OFF_CTRL, 8'h41);
    $display("test priority done");
  endtask : t_prio

  task t_port();
    @(posedge pclk) upper_port_b_pins <= 4'h5;
    repeat (6) @(posedge pclk);
    rdchk(tlic_pkg::OFF_MAIN, 8'h01, "port change flag");
    wr(tlic_pkg::OFF_MAIN, 8'h00);
    rdchk(tlic_pkg::OFF_MAIN, 8'h01, "mismatch keeps flag");
    @(posedge pclk) port_b_read <= 1'b1;
    @(posedge pclk) port_b_read <= 1'b0;
    repeat (2) @(posedge pclk);
    wr(tlic_pkg::OFF_MAIN, 8'h00);
    rdchk(tlic_pkg::OFF_MAIN, 8'h00, "flag clears after read");
    $display("test port done");
  endtask : t_port

  // Main sequence; every input has a value before the first edge
  initial begin
    n_mismatch        = 0;
    cmp_count         = 0;
    cycles            = 0;
    presetn           = 1'b0;
    apb_req           = '0;
    timer0_overflow   = 1'b0;
    ext_irq_pin_zero  = 1'b0;
    upper_port_b_pins = 4'h0;
    port_b_read       = 1'b0;
    periph_irq_flag   = '0;
    ack_en            = 1'b0;
    ack_dly           = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_compat_timer();
    t_pin();
    t_prio();
    t_port();
    print_verdict();
  end
endmodule : two_level_interrupt_controller_tb

// file: src/tlic_pkg.sv
// How it works
// - Two priority levels; high vectors to 000008h, low to 000018h.
// - High requests preempt low service; low never preempts high service.
// - Each source has a flag and an enable; all but the pin have a priority selector.
// - Priority works only while priority_mode_enable is set; reset leaves it clear.
// - With priorities, bit 7 admits high sources and bit 6 low sources.
// - Flag, enable, bit 7 and, for low sources and compatibility-mode peripherals, bit 6 together raise the vector request.
// - In compatibility mode every priority bit is ignored.
// - In compatibility mode bit 6 gates peripherals, bit 7 gates everything.
// - In compatibility mode every interrupt vectors to 000008h.
// - Acceptance clears the global enable that admitted the interrupt.
// - Acceptance pushes the return address and loads the vector into the PC.
// - Return-from-interrupt sets the global enable of the level it leaves.
// - Pin events reach the vector in three to four cycles, port-change events in four to five.
// - Flags set on their event whatever the enables say.
// - With priorities, bit 7 set admits high interrupts, clear blocks all.
// - With priorities, bit 6 admits low peripheral interrupts.
// - Main register bits 5, 4, 3 enable timer, pin and port-change sources.
// - Bit 2 sets on timer overflow and holds until software clears it.
// - Bit 1 sets on the pin event and holds until software clears it.
// - Bit 0 sets when an upper port B pin changes, held until cleared.
// - A persisting port mismatch keeps setting the flag until the port is read.
package tlic_pkg;

  // Register byte offsets on the APB side
  localparam logic [7:0] OFF_MAIN   = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_PERIPH = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // Main register bit positions
  localparam int B_GIE_HI  = 7;
  localparam int B_GIE_LO  = 6;
  localparam int B_TMR_EN  = 5;
  localparam int B_PIN_EN  = 4;
  localparam int B_PORT_EN = 3;
  localparam int B_TMR_FL  = 2;
  localparam int B_PIN_FL  = 1;
  localparam int B_PORT_FL = 0;

  // Control register bit positions
  localparam int B_PRIO_MODE = 7;
  localparam int B_PIN_RISE  = 6;
  localparam int B_TMR_PRIO  = 2;
  localparam int B_PORT_PRIO = 0;

  // Reset values
  localparam logic [7:0] RST_MAIN   = 8'h00;
  localparam logic [7:0] RST_CTRL   = 8'h45;
  localparam logic [7:0] RST_PERIPH = 8'hf0;

  // Vector addresses
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW  = 21'h000018;

  // Number of peripheral request lines
  localparam int NPER = 4;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tlic_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tlic_apb_rsp_t;

  typedef struct packed {
    logic        req;
    logic [20:0] vector;
    logic        pc_load;
    logic        stack_push;
  } tlic_core_t;

endpackage : tlic_pkg

// file: src/tlic_top.sv
`timescale 1ns/100ps
module tlic_top (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire tlic_pkg::tlic_apb_req_t apb_req,
  output tlic_pkg::tlic_apb_rsp_t      apb_rsp,
  // Event sources
  input  wire logic                  timer0_overflow,
  input  wire logic                  ext_irq_pin_zero,
  input  wire logic [3:0]            upper_port_b_pins,
  input  wire logic                  port_b_read,
  input  wire logic [tlic_pkg::NPER-1:0] periph_irq_flag,
  // Core sequencer
  input  wire logic                  irq_ack,
  input  wire logic                  return_from_irq_instr,
  output tlic_pkg::tlic_core_t         core_out
);

  // Register state
  logic [7:0] main_q, main_d;
  logic [7:0] ctrl_q;
  logic [7:0] periph_q;
  logic       act_hi_q, act_lo_q;
  tlic_pkg::tlic_apb_rsp_t rsp_q;
  tlic_pkg::tlic_core_t    core_q;

  // Pin synchronisers, three stages each
  logic [2:0] pin_s_q;
  logic [3:0] port_s1_q, port_s2_q, port_s3_q;
  logic [3:0] port_latch_q;

  // Any bit of a masked set
  function automatic logic any_set(input logic [7:0] v);
    return |v;
  endfunction : any_set

  // APB decode
  wire access   = apb_req.psel && apb_req.penable && !rsp_q.pready;
  // Writes land at the edge where the master samples pready high
  wire wr_go    = apb_req.psel && apb_req.penable && apb_req.pwrite && rsp_q.pready;
  wire wr_main  = wr_go && apb_req.paddr == tlic_pkg::OFF_MAIN;
  wire wr_ctrl  = wr_go && apb_req.paddr == tlic_pkg::OFF_CTRL;
  wire wr_per   = wr_go && apb_req.paddr == tlic_pkg::OFF_PERIPH;
  wire hit      = apb_req.paddr == tlic_pkg::OFF_MAIN || apb_req.paddr == tlic_pkg::OFF_CTRL ||
                  apb_req.paddr == tlic_pkg::OFF_PERIPH || apb_req.paddr == tlic_pkg::OFF_STATUS;
  wire bad_wr   = apb_req.pwrite && apb_req.paddr == tlic_pkg::OFF_STATUS;

  // Mode and global enables
  wire priority_mode_enable     = ctrl_q[tlic_pkg::B_PRIO_MODE];
  wire gie_hi   = main_q[tlic_pkg::B_GIE_HI];
  wire gie_lo   = main_q[tlic_pkg::B_GIE_LO];

  // Event detection; only settled sync stages are compared
  wire pin_rise  = pin_s_q[1] && !pin_s_q[2];
  wire pin_fall  = !pin_s_q[1] && pin_s_q[2];
  wire pin_ev    = ctrl_q[tlic_pkg::B_PIN_RISE] ? pin_rise : pin_fall;
  wire port_agree = (port_s2_q == port_s3_q);
  wire port_mis  = port_agree && (port_s3_q != port_latch_q);

  // Per-source pending terms: flag and enable
  wire tmr_on  = main_q[tlic_pkg::B_TMR_FL]  && main_q[tlic_pkg::B_TMR_EN];
  wire pin_on  = main_q[tlic_pkg::B_PIN_FL]  && main_q[tlic_pkg::B_PIN_EN];
  wire port_on = main_q[tlic_pkg::B_PORT_FL] && main_q[tlic_pkg::B_PORT_EN];
  wire [3:0] per_on   = periph_irq_flag & periph_q[3:0];
  wire [3:0] per_prio = periph_q[7:4];

  // Pin source has no priority selector and always counts as high
  wire [7:0] hi_set = {1'b0, per_on & per_prio,
                       tmr_on && ctrl_q[tlic_pkg::B_TMR_PRIO], pin_on,
                       port_on && ctrl_q[tlic_pkg::B_PORT_PRIO]};
  wire [7:0] lo_set = {1'b0, per_on & ~per_prio,
                       tmr_on && !ctrl_q[tlic_pkg::B_TMR_PRIO], 1'b0,
                       port_on && !ctrl_q[tlic_pkg::B_PORT_PRIO]};

  // Bit 7 low blocks everything in both modes
  wire pend_hi  = priority_mode_enable && gie_hi && any_set(hi_set);
  wire pend_lo  = priority_mode_enable && gie_hi && gie_lo && !act_hi_q && any_set(lo_set);
  // Compatibility: priority bits ignored, bit 6 gates peripherals only
  wire pend_cm  = !priority_mode_enable && gie_hi &&
                  (tmr_on || pin_on || port_on || (gie_lo && (|per_on)));
  wire pend_any = pend_hi || pend_lo || pend_cm;
  // High wins when both levels pend; compatibility always uses the high vector
  wire [20:0] vec_sel = pend_lo && !pend_hi ? tlic_pkg::VEC_LOW : tlic_pkg::VEC_HIGH;

  // Acceptance and return
  wire take     = irq_ack && core_q.req;
  wire take_lo  = take && priority_mode_enable && core_q.vector == tlic_pkg::VEC_LOW;
  wire take_hi  = take && !take_lo;
  wire ret_hi   = return_from_irq_instr && (!priority_mode_enable || act_hi_q);
  wire ret_lo   = return_from_irq_instr && priority_mode_enable && !act_hi_q;

  // Read mux
  logic [7:0] rd_byte;
  always_comb begin
    case (apb_req.paddr)
      tlic_pkg::OFF_MAIN:   rd_byte = main_q;
      tlic_pkg::OFF_CTRL:   rd_byte = ctrl_q;
      tlic_pkg::OFF_PERIPH: rd_byte = periph_q;
      tlic_pkg::OFF_STATUS: rd_byte = {1'b0, core_q.req, act_lo_q, act_hi_q, periph_irq_flag};
      default:              rd_byte = 8'h00;
    endcase
  end

  // Main register next value; hardware set wins over a software clear
  always_comb begin
    main_d = main_q;
    if (wr_main) begin
      main_d = apb_req.pwdata[7:0];
    end
    if (take_hi) begin
      main_d[tlic_pkg::B_GIE_HI] = 1'b0;
    end
    if (take_lo) begin
      main_d[tlic_pkg::B_GIE_LO] = 1'b0;
    end
    if (ret_hi) begin
      main_d[tlic_pkg::B_GIE_HI] = 1'b1;
    end
    if (ret_lo) begin
      main_d[tlic_pkg::B_GIE_LO] = 1'b1;
    end
    if (timer0_overflow) begin
      main_d[tlic_pkg::B_TMR_FL] = 1'b1;
    end
    if (pin_ev) begin
      main_d[tlic_pkg::B_PIN_FL] = 1'b1;
    end
    if (port_mis) begin
      main_d[tlic_pkg::B_PORT_FL] = 1'b1;
    end
  end

  // Main control register, enables at bits 5..3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_q <= tlic_pkg::RST_MAIN;
    end else begin
      main_q <= main_d;
    end
  end

  // Control and peripheral registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= tlic_pkg::RST_CTRL;
      periph_q <= tlic_pkg::RST_PERIPH;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= apb_req.pwdata[7:0];
      end
      if (wr_per) begin
        periph_q <= apb_req.pwdata[7:0];
      end
    end
  end

  // Service level tracking; a high entry may nest over a low one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_hi_q <= 1'b0;
      act_lo_q <= 1'b0;
    end else begin
      if (take_hi) begin
        act_hi_q <= 1'b1;
      end else if (ret_hi) begin
        act_hi_q <= 1'b0;
      end
      if (take_lo) begin
        act_lo_q <= 1'b1;
      end else if (ret_lo || (return_from_irq_instr && !priority_mode_enable)) begin
        act_lo_q <= 1'b0;
      end
    end
  end

  // Synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s_q   <= 3'h0;
      port_s1_q <= 4'h0;
      port_s2_q <= 4'h0;
      port_s3_q <= 4'h0;
    end else begin
      pin_s_q   <= {pin_s_q[1:0], ext_irq_pin_zero};
      port_s1_q <= upper_port_b_pins;
      port_s2_q <= port_s1_q;
      port_s3_q <= port_s2_q;
    end
  end

  // Port read latch; reading the port ends the mismatch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch_q <= 4'h0;
    end else if (port_b_read && port_agree) begin
      port_latch_q <= port_s3_q;
    end
  end

  // Core request; dropped at acceptance so one request yields one entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_q <= '0;
    end else begin
      core_q.req        <= pend_any && !take;
      core_q.vector     <= take ? core_q.vector : vec_sel;
      core_q.pc_load    <= take;
      core_q.stack_push <= take;
    end
  end

  // APB answer after one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready  <= access;
      rsp_q.pslverr <= access && (!hit || bad_wr);
      rsp_q.prdata  <= (access && !apb_req.pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  assign apb_rsp  = rsp_q;
  assign core_out = core_q;

  // Checks
  sequence s_take;
    irq_ack && core_q.req;
  endsequence

  property p_compat_vec;
    @(posedge pclk) disable iff (!presetn)
      core_q.pc_load && !priority_mode_enable |-> core_q.vector == tlic_pkg::VEC_HIGH;
  endproperty
  a_compat_vec: assert property (p_compat_vec) else $error("compat vector not high");

  property p_take_clears;
    @(posedge pclk) disable iff (!presetn)
      s_take ##0 !priority_mode_enable |=> !gie_hi;
  endproperty
  a_take_clears: assert property (p_take_clears) else $error("global enable kept");

  property p_take_push;
    @(posedge pclk) disable iff (!presetn)
      s_take |=> core_q.pc_load && core_q.stack_push ##1 !core_q.pc_load;
  endproperty
  a_take_push: assert property (p_take_push) else $error("no push on accept");

  property p_ret_sets;
    @(posedge pclk) disable iff (!presetn)
      return_from_irq_instr && !priority_mode_enable |=> gie_hi;
  endproperty
  a_ret_sets: assert property (p_ret_sets) else $error("return left enable clear");

  property p_tmr_flag;
    @(posedge pclk) disable iff (!presetn)
      timer0_overflow |=> main_q[tlic_pkg::B_TMR_FL];
  endproperty
  a_tmr_flag: assert property (p_tmr_flag) else $error("timer flag lost");

  property p_pin_flag;
    @(posedge pclk) disable iff (!presetn)
      pin_ev |=> main_q[tlic_pkg::B_PIN_FL];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag lost");

  property p_port_keep;
    @(posedge pclk) disable iff (!presetn)
      port_mis |=> main_q[tlic_pkg::B_PORT_FL];
  endproperty
  a_port_keep: assert property (p_port_keep) else $error("port flag cleared in mismatch");

  property p_hi_gate;
    @(posedge pclk) disable iff (!presetn)
      !gie_hi ##1 !gie_hi |-> !core_q.req;
  endproperty
  a_hi_gate: assert property (p_hi_gate) else $error("request with bit 7 clear");

  property p_no_low_over_high;
    @(posedge pclk) disable iff (!presetn)
      act_hi_q && $past(act_hi_q) && core_q.req |-> core_q.vector == tlic_pkg::VEC_HIGH;
  endproperty
  a_no_low_over_high: assert property (p_no_low_over_high) else $error("low preempted high");

endmodule : tlic_top
